// file: core/bsc_pkg.sv
// shared constants and types for the speed command and advance block
package bsc_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] SPD_OFS  = 8'h04;
   localparam logic [7:0] ADV_OFS  = 8'h08;
   localparam logic [7:0] DMD_OFS  = 8'h0C;
   localparam logic [7:0] TADV_OFS = 8'h10;
   // control register field positions
   localparam int SRC_BIT   = 0;
   localparam int RATE_BIT  = 1;
   localparam int OVR_BIT   = 2;
   localparam int AMODE_BIT = 3;
   localparam int SLEW_LSB  = 4;
   localparam int ATTN_LSB  = 7;
   // reset values and maximum demand
   localparam logic [8:0] CTRL_RST = 9'h000;
   localparam logic [8:0] SPD_RST  = 9'h000;
   localparam logic [6:0] ADV_RST  = 7'h00;
   localparam logic [8:0] DMD_MAX  = 9'h1FF;
   // timing
   localparam int CLK_NS      = 100;
   localparam int CLK_HZ      = 10_000_000;
   localparam int ADV_UNIT_NS = 2500;
   localparam int ADV_UNIT_CYC = ADV_UNIT_NS / CLK_NS;
   localparam int PWM_LO_HZ   = 25_000;
   localparam int PWM_HI_HZ   = 50_000;
   localparam logic [8:0] PER_LO = 9'(CLK_HZ / PWM_LO_HZ);
   localparam logic [8:0] PER_HI = 9'(CLK_HZ / PWM_HI_HZ);
   localparam int LOW_STOP_US  = 1000;
   localparam int LOW_STOP_CYC = LOW_STOP_US * 1000 / CLK_NS;
   localparam logic [8:0] PWM_WIN_LAST = 9'h1FE;
   localparam logic [11:0] SLEW_BASE_CYC = 12'h010;
   localparam logic [4:0] DIV_STEPS = 5'h19;
   // axi responses
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   // software controls
   typedef struct packed {
      logic [1:0] atten;
      logic [2:0] slew;
      logic       amode;
      logic       ovr;
      logic       rate;
      logic       src;
   } bsc_ctrl_t;
   // divider states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_DIV  = 2'b10
   } bsc_div_t;
endpackage : bsc_pkg

// file: core/bsc_top.sv
// speed demand selection, slew limit, feedback attenuation and advance time
// Summary of operation
// [RQ1] source bit 0: speed pin is an analog level, ground to 3.3 V rail
// [RQ2] analog level above full-scale gives maximum demand
// [RQ3] analog level between zero and full scale gives linear demand
// [RQ4] analog level below zero-scale gives a stop demand
// [RQ5] source bit 1: speed pin decoded as PWM, duty 0 to 100 percent
// [RQ6] PWM mode demand proportional to measured duty cycle
// [RQ7] PWM input low for the stop time commands a stop
// [RQ8] phase PWM at 25 kHz for rate bit 0, 50 kHz for 1
// [RQ9] serial serial_speed_a bit 1 takes demand from serial speed register
// [RQ10] under serial_speed_a the speed pin is ignored
// [RQ11] 9-bit serial value sets peak drive amplitude
// [RQ12] serial value all ones is maximum demand
// [RQ13] demand changes no faster than the 3-bit slew field allows
// [RQ14] 2-bit field attenuates the current feedback
// [RQ15] drive voltage leads estimated back-EMF by an advance time
// [RQ16] advance mode bit 0 selects mode 0, 1 selects mode 1
// [RQ17] mode 0 keeps advance fixed at the setting
// [RQ18] mode 1 scales setting by (amplitude minus back-EMF) over amplitude
// [RQ19] setting is 2.5 us times mantissa shifted by exponent
// [RQ20] analog and PWM demands use the serial 9-bit scale
// [RQ21] host programs fields first and switches source only when stopped
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
module bsc_top
   import bsc_pkg::*;
#(
   parameter int                 ADC_W      = 10,
   parameter logic [ADC_W-1:0]   ANA_ZS     = 10'h040,
   parameter logic [ADC_W-1:0]   ANA_FS     = 10'h3C0,
   parameter int                 FB_W       = 12,
   parameter logic [23:0]        LOW_STOP_N = 24'(LOW_STOP_CYC)
)
(
   // clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // axi4-lite write
   input  wire logic [7:0]       s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]       s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   // speed pin, digitised level and motor estimates
   input  wire logic             speed_pin,
   input  wire logic [ADC_W-1:0] adc_level,
   input  wire logic [8:0]       phase_amp,
   input  wire logic [8:0]       bemf_amp,
   input  wire logic [FB_W-1:0]  fb_in,
   // results
   output logic                  phase_pwm,
   output logic [8:0]            speed_demand,
   output logic                  motor_stop,
   output logic [FB_W-1:0]       fb_out,
   output logic [15:0]           adv_cycles
);

   typedef struct packed {
      bsc_ctrl_t        ctrl;
      logic [8:0]       spd;
      logic [6:0]       adv;
      logic             awready;
      logic             wready;
      logic             aw_got;
      logic             w_got;
      logic [7:0]       waddr;
      logic [31:0]      wdata;
      logic [3:0]       wstrb;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             arready;
      logic             rvalid;
      logic [1:0]       rresp;
      logic [31:0]      rdata;
      logic             sp_s1;
      logic             sp_s2;
      logic [8:0]       win;
      logic [8:0]       hi;
      logic [8:0]       pwm_dmd;
      logic [23:0]      low_cnt;
      logic [8:0]       tgt;
      logic [8:0]       dmd;
      logic [11:0]      slew_cnt;
      logic [8:0]       car;
      logic             pwm;
      logic             stop;
      logic [FB_W-1:0]  fb;
      bsc_div_t         st;
      logic [4:0]       dcnt;
      logic [24:0]      dsh;
      logic [9:0]       rem;
      logic [24:0]      quo;
      logic [8:0]       dvs;
      logic [15:0]      adv_cyc;
   } bsc_state_t;

   bsc_state_t st_r;
   bsc_state_t st_nxt;

   // combinational helpers
   logic [15:0]      set_cyc;
   logic [8:0]       ana_dmd;
   logic [18:0]      ana_prod;
   logic [8:0]       per;
   logic [17:0]      thr;
   logic [11:0]      slew_lim;
   logic [24:0]      num;
   logic [9:0]       trial;
   logic [31:0]      rd_word;
   logic             rd_hit;
   logic             wr_hit;
   // advance setting in clock cycles, one unit is 2.5 us
   // [RQ19] mantissa shifted
   assign set_cyc = 16'(16'({12'h000, st_r.adv[3:0]} << st_r.adv[6:4])
                        * 16'(ADV_UNIT_CYC));
   // analog level onto the 9-bit demand scale
   // [RQ20] common demand scale
   assign ana_prod = 19'(adc_level - ANA_ZS) * 19'(DMD_MAX);
   assign ana_dmd  = 9'(ana_prod / 19'(ANA_FS - ANA_ZS));
   // carrier period and compare level from the current demand
   assign per = st_r.ctrl.rate ? PER_HI : PER_LO;
   assign thr = 18'(st_r.dmd) * 18'(per);
   // slew interval doubles with each step of the field
   assign slew_lim = SLEW_BASE_CYC << st_r.ctrl.slew;
   // mode 1 dividend; back-EMF above amplitude clamps to zero advance
   assign num = (bemf_amp >= phase_amp) ? 25'h0000000
              : 25'(set_cyc) * 25'(phase_amp - bemf_amp);
   assign trial = {st_r.rem[8:0], st_r.dsh[24]};
   // register read decode; unmapped reads return zero with an error
   always_comb
   begin
      rd_word = 32'h00000000;
      rd_hit  = 1'b1;
      unique case (s_axi_araddr)
         CTRL_OFS: rd_word = {23'h000000, st_r.ctrl};
         SPD_OFS:  rd_word = {23'h000000, st_r.spd};
         ADV_OFS:  rd_word = {25'h0000000, st_r.adv};
         DMD_OFS:  rd_word = {23'h000000, st_r.dmd};
         TADV_OFS: rd_word = {16'h0000, st_r.adv_cyc};
         default:  rd_hit  = 1'b0;
      endcase
   end
   // writable registers; read-only and unmapped writes answer an error
   assign wr_hit = (st_r.waddr == CTRL_OFS) || (st_r.waddr == SPD_OFS)
                || (st_r.waddr == ADV_OFS);
   // next state of the whole block
   always_comb
   begin
      st_nxt = st_r;

      // write channel capture, address and data in either order
      if (s_axi_awvalid && st_r.awready)
      begin
         st_nxt.aw_got = 1'b1;
         st_nxt.waddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.wready)
      begin
         st_nxt.w_got = 1'b1;
         st_nxt.wdata = s_axi_wdata;
         st_nxt.wstrb = s_axi_wstrb;
      end
      if (st_r.bvalid && s_axi_bready)
         st_nxt.bvalid = 1'b0;
      // commit once both halves are held and the last answer is gone
      if (st_r.aw_got && st_r.w_got && !st_r.bvalid)
      begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = wr_hit ? RESP_OK : RESP_ERR;
         unique case (st_r.waddr)
            CTRL_OFS:
               st_nxt.ctrl = bsc_ctrl_t'({st_r.wstrb[1] ? st_r.wdata[8] : st_r.ctrl[8],
                                          st_r.wstrb[0] ? st_r.wdata[7:0] : st_r.ctrl[7:0]});
            SPD_OFS:
               st_nxt.spd = {st_r.wstrb[1] ? st_r.wdata[8] : st_r.spd[8],
                             st_r.wstrb[0] ? st_r.wdata[7:0] : st_r.spd[7:0]};
            ADV_OFS:
               if (st_r.wstrb[0])
                  st_nxt.adv = st_r.wdata[6:0];
            default: st_nxt.bresp = RESP_ERR;
         endcase
      end
      st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
      st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;

      // read channel, one outstanding read
      if (st_r.rvalid && s_axi_rready)
         st_nxt.rvalid = 1'b0;
      if (s_axi_arvalid && st_r.arready)
      begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = rd_word;
         st_nxt.rresp  = rd_hit ? RESP_OK : RESP_ERR;
      end
      st_nxt.arready = !st_nxt.rvalid;

      // pin synchroniser; only the second stage feeds logic
      st_nxt.sp_s1 = speed_pin;
      st_nxt.sp_s2 = st_r.sp_s1;

      // duty measured over a 511-cycle window, so the count is the demand
      // [RQ5] pwm decode
      if (st_r.win == PWM_WIN_LAST)
      begin
         st_nxt.win = 9'h000;
         st_nxt.hi  = 9'h000;
         // [RQ6] duty proportional
         st_nxt.pwm_dmd = st_r.hi + {8'h00, st_r.sp_s2};
      end
      else
      begin
         st_nxt.win = st_r.win + 9'h001;
         st_nxt.hi  = st_r.hi + {8'h00, st_r.sp_s2};
      end
      // low time saturates so a long idle input holds the stop
      if (st_r.sp_s2)
         st_nxt.low_cnt = 24'h000000;
      else if (st_r.low_cnt != LOW_STOP_N)
         st_nxt.low_cnt = st_r.low_cnt + 24'h000001;

      // source selection, serial_speed_a first
      if (st_r.ctrl.ovr)
         // [RQ9] serial value wins, [RQ10] pin ignored, [RQ11] [RQ12]
         st_nxt.tgt = st_r.spd;
      else if (st_r.ctrl.src)
      begin
         // [RQ7] low input stop
         if (st_r.low_cnt == LOW_STOP_N)
            st_nxt.tgt = 9'h000;
         else
            st_nxt.tgt = st_r.pwm_dmd;
      end
      else
      begin
         // [RQ1] analog mode, [RQ2] [RQ3] [RQ4] three bands
         if (adc_level > ANA_FS)
            st_nxt.tgt = DMD_MAX;
         else if (adc_level >= ANA_ZS)
            st_nxt.tgt = ana_dmd;
         else
            st_nxt.tgt = 9'h000;
      end
      st_nxt.stop = (st_nxt.tgt == 9'h000);

      // one demand step per slew interval toward the target
      // [RQ13] rate limited demand
      if (st_r.dmd == st_r.tgt)
         st_nxt.slew_cnt = 12'h000;
      else if (st_r.slew_cnt >= slew_lim - 12'h001)
      begin
         st_nxt.slew_cnt = 12'h000;
         if (st_r.dmd < st_r.tgt)
            st_nxt.dmd = st_r.dmd + 9'h001;
         else
            st_nxt.dmd = st_r.dmd - 9'h001;
      end
      else
         st_nxt.slew_cnt = st_r.slew_cnt + 12'h001;

      // phase carrier; the demand sets the duty, i.e. the amplitude
      // [RQ8] carrier rate
      if (st_r.car >= per - 9'h001)
         st_nxt.car = 9'h000;
      else
         st_nxt.car = st_r.car + 9'h001;
      st_nxt.pwm = (st_r.car < thr[17:9]);

      // feedback attenuation by right shift
      // [RQ14] attenuated feedback
      st_nxt.fb = fb_in >> st_r.ctrl.atten;

      // advance time; the divider reruns continuously in mode 1
      // [RQ15] lead time
      unique case (st_r.st)
         ST_IDLE:
         begin
            // [RQ16] method select
            if (st_r.ctrl.amode)
            begin
               st_nxt.st   = ST_DIV;
               st_nxt.dsh  = num;
               st_nxt.dvs  = phase_amp;
               st_nxt.rem  = 10'h000;
               st_nxt.quo  = 25'h0000000;
               st_nxt.dcnt = 5'h00;
            end
            else
               // [RQ17] fixed advance
               st_nxt.adv_cyc = set_cyc;
         end
         ST_DIV:
         begin
            // [RQ18] restoring division, one quotient bit a cycle
            st_nxt.dsh = {st_r.dsh[23:0], 1'b0};
            st_nxt.rem = (trial >= {1'b0, st_r.dvs}) ? trial - {1'b0, st_r.dvs} : trial;
            st_nxt.quo = {st_r.quo[23:0], trial >= {1'b0, st_r.dvs}};
            st_nxt.dcnt = st_r.dcnt + 5'h01;
            if (st_r.dcnt == DIV_STEPS - 5'h01)
            begin
               st_nxt.st      = ST_IDLE;
               st_nxt.adv_cyc = st_nxt.quo[15:0];
            end
         end
         default: st_nxt.st = ST_IDLE;
      endcase
   end
   // single state register, synchronous reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r       <= '0;
         st_r.ctrl  <= CTRL_RST;
         st_r.spd   <= SPD_RST;
         st_r.adv   <= ADV_RST;
         st_r.st    <= ST_IDLE;
         st_r.stop  <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end
   // outputs straight from the state register
   assign s_axi_awready = st_r.awready;
   assign s_axi_wready  = st_r.wready;
   assign s_axi_bvalid  = st_r.bvalid;
   assign s_axi_bresp   = st_r.bresp;
   assign s_axi_arready = st_r.arready;
   assign s_axi_rvalid  = st_r.rvalid;
   assign s_axi_rresp   = st_r.rresp;
   assign s_axi_rdata   = st_r.rdata;
   assign phase_pwm     = st_r.pwm;
   assign speed_demand  = st_r.dmd;
   assign motor_stop    = st_r.stop;
   assign fb_out        = st_r.fb;
   assign adv_cycles    = st_r.adv_cyc;
   // serial_speed_a follows the serial register
   sequence ovr_held_s;
      st_r.ctrl.ovr && $stable(st_r.spd);
   endsequence
   serial_serial_speed_a_a : assert property (   // [RQ9]
      @(posedge aclk) disable iff (!aresetn)
      ovr_held_s |=> (st_r.tgt == $past(st_r.spd)))
      else $error("serial_speed_a target differs from serial value");
   analog_full_a : assert property (   // [RQ2]
      @(posedge aclk) disable iff (!aresetn)
      (!st_r.ctrl.ovr && !st_r.ctrl.src && adc_level > ANA_FS)
      |=> (st_r.tgt == DMD_MAX))
      else $error("analog above full scale not maximum");
   analog_stop_a : assert property (   // [RQ4]
      @(posedge aclk) disable iff (!aresetn)
      (!st_r.ctrl.ovr && !st_r.ctrl.src && adc_level < ANA_ZS)
      |=> (st_r.tgt == 9'h000) && motor_stop)
      else $error("analog below zero scale did not stop");
   pwm_stop_a : assert property (   // [RQ7]
      @(posedge aclk) disable iff (!aresetn)
      (!st_r.ctrl.ovr && st_r.ctrl.src && st_r.low_cnt == LOW_STOP_N)
      |=> (st_r.tgt == 9'h000))
      else $error("long low input did not stop");
   slew_step_a : assert property (   // [RQ13]
      @(posedge aclk) disable iff (!aresetn)
      (st_r.dmd != $past(st_r.dmd)) |-> ($past(st_r.slew_cnt) != 12'h000
      || slew_lim == 12'h001) && (st_r.dmd - $past(st_r.dmd) == 9'h001
      || $past(st_r.dmd) - st_r.dmd == 9'h001))
      else $error("demand moved more than one step");
   feedback_shift_a : assert property (   // [RQ14]
      @(posedge aclk) disable iff (!aresetn)
      ##1 (fb_out == ($past(fb_in) >> $past(st_r.ctrl.atten))))
      else $error("feedback attenuation wrong");
   fixed_advance_a : assert property (   // [RQ17]
      @(posedge aclk) disable iff (!aresetn)
      (st_r.st == ST_IDLE && !st_r.ctrl.amode) |=> adv_cycles == $past(set_cyc))
      else $error("mode 0 advance not the setting");
   sequence div_run_s;
      (st_r.st == ST_IDLE && st_r.ctrl.amode) ##1 (st_r.st == ST_DIV) [*8];
   endsequence
   divide_done_a : assert property (   // [RQ18]
      @(posedge aclk) disable iff (!aresetn)
      div_run_s |-> ##[1:20] (st_r.st == ST_IDLE))
      else $error("advance division did not finish");
   carrier_wrap_a : assert property (   // [RQ8]
      @(posedge aclk) disable iff (!aresetn)
      (st_r.car == per - 9'h001) |=> (st_r.car == 9'h000))
      else $error("carrier period wrong");
endmodule : bsc_top

// file: tb/bsc_speed_host.sv
// pwm source standing in for the host that drives the speed pin
`timescale 1ns/1ns
module bsc_speed_host
(
   // clock
   input  wire logic        aclk,
   // high and low time of one input period, in clock cycles
   input  wire logic [15:0] hi_cyc,
   input  wire logic [15:0] lo_cyc,
   // pin toward the block
   output logic             speed_pin
);
   logic [15:0] cnt;

   initial
   begin
      cnt = 16'h0000;
      speed_pin = 1'b0;
   end

   // duty from none to full
   // zero low time holds the pin high, zero high time holds it low
   always @(posedge aclk)
   begin
      cnt <= (cnt + 16'h0001 >= hi_cyc + lo_cyc) ? 16'h0000 : cnt + 16'h0001;
      speed_pin <= (cnt < hi_cyc);
   end
endmodule : bsc_speed_host

// file: tb/bsc_top_tb_top.sv
// self-checking bench for the speed command and advance block
`timescale 1ns/1ns
module bsc_top_tb_top;
   import bsc_pkg::*;
   localparam logic [23:0] STOP_N = 24'h000032;
   localparam logic [7:0]  RA [6] = '{CTRL_OFS, SPD_OFS, ADV_OFS, DMD_OFS, TADV_OFS, 8'h14};
   localparam logic [9:0]  LV [4] = '{10'h03F, 10'h200, 10'h3C1, 10'h3FF};
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, speed_pin, phase_pwm, motor_stop;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [9:0]  adc_level;
   logic [8:0]  phase_amp, bemf_amp, speed_demand;
   logic [11:0] fb_in, fb_out;
   logic [15:0] adv_cycles, hi_cyc, lo_cyc;
   logic        pwm_q;
   int          per_cnt, hi_cnt, last_per, last_hi, failures, checks_done;
   logic [33:0] rq[$];
   logic [1:0]  wq[$];

   bsc_top #(.LOW_STOP_N(STOP_N)) DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .speed_pin(speed_pin), .adc_level(adc_level), .phase_amp(phase_amp),
      .bemf_amp(bemf_amp), .fb_in(fb_in), .phase_pwm(phase_pwm),
      .speed_demand(speed_demand), .motor_stop(motor_stop), .fb_out(fb_out),
      .adv_cycles(adv_cycles));

   bsc_speed_host host (.aclk(aclk), .hi_cyc(hi_cyc), .lo_cyc(lo_cyc), .speed_pin(speed_pin));

   // clock
   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   task automatic hang;
      failures++;
      tally_and_finish();
   endtask : hang

   task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
      checks_done++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // response watcher: oldest note against each answer as it appears
   always @(posedge aclk)
   begin
      if (bvalid && bready)
         chk("bresp", {32'h0, wq.pop_front()}, {32'h0, bresp});
      if (rvalid && rready)
         chk("rresp_rdata", rq.pop_front(), {rresp, rdata});
   end

   // carrier period and high time between rising edges
   always @(posedge aclk)
   begin
      pwm_q <= phase_pwm;
      per_cnt <= (phase_pwm && !pwm_q) ? 1 : per_cnt + 1;
      hi_cnt <= (phase_pwm && !pwm_q) ? 1 : hi_cnt + int'(phase_pwm);
      if (phase_pwm && !pwm_q)
      begin
         last_per <= per_cnt;
         last_hi <= hi_cnt;
      end
   end

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      int n;
      @(posedge aclk);
      wq.push_back(e);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         n++;
      end
      while (!(bvalid && bready) && n < 100);
      bready <= 1'b0;
      if (n >= 100)
         hang();
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      int n;
      @(posedge aclk);
      rq.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         n++;
      end
      while (!(rvalid && rready) && n < 100);
      rready <= 1'b0;
      if (n >= 100)
         hang();
   endtask : rd

   task automatic wait_stop(input logic v, input int lim);
      int n;
      n = 0;
      while (motor_stop !== v && n < lim)
      begin
         @(posedge aclk);
         n++;
      end
      if (n >= lim)
         hang();
      chk("motor_stop", {33'h0, v}, {33'h0, motor_stop});
   endtask : wait_stop

   task automatic wait_dmd(input logic [8:0] v, input int lim, output int n);
      n = 0;
      while (speed_demand !== v && n < lim)
      begin
         @(posedge aclk);
         n++;
      end
      if (n >= lim)
         hang();
      chk("speed_demand", {25'h0, v}, {25'h0, speed_demand});
   endtask : wait_dmd

   function automatic logic [31:0] ctl(input logic s, r, o, m, input logic [2:0] sl,
                                       input logic [1:0] at);
      return {23'h0, at, sl, m, o, r, s};
   endfunction : ctl

   task automatic adv(input logic [6:0] c, input logic m, input logic [15:0] e);
      int n;
      wr(ADV_OFS, {25'h0, c}, RESP_OK);
      wr(CTRL_OFS, ctl(0, 0, 0, m, 3'h0, 2'h0), RESP_OK);
      n = 0;
      while (adv_cycles !== e && n < 200)
      begin
         @(posedge aclk);
         n++;
      end
      if (n >= 200)
         hang();
      rd(TADV_OFS, {RESP_OK, 16'h0, e});
   endtask : adv

   task automatic pwm_per(input int p);
      repeat (3 * p) @(posedge aclk);
      chk("carrier_period", 34'(p), 34'(last_per));
      chk("carrier_high_ok", 34'h1,
          {33'h0, last_hi >= 511 * p / 512 - 1 && last_hi <= 511 * p / 512});
   endtask : pwm_per

   // main sequence
   initial
   begin
      int n, t;
      logic [31:0] v;
      logic [6:0] c;
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata} = 48'h0;
      {hi_cyc, lo_cyc, adc_level, fb_in} = 54'h0;
      phase_amp = 9'h100;
      bemf_amp = 9'h080;
      failures = 0;
      checks_done = 0;
      void'($urandom(47736));
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      // reset values, then an unmapped place
      foreach (RA[i])
         rd(RA[i], {i == 5 ? RESP_ERR : RESP_OK, 32'h0});
      // read-only and unmapped writes are refused without effect
      wr(DMD_OFS, 32'h1FF, RESP_ERR);
      wr(8'h14, 32'h1FF, RESP_ERR);
      rd(DMD_OFS, {RESP_OK, 32'h0});
      for (int i = 0; i < 3; i++)
      begin
         v = 32'($urandom) & (i == 2 ? 32'h7F : 32'h1FF);
         wr(RA[i], v, RESP_OK);
         rd(RA[i], {RESP_OK, v});
      end
      wr(SPD_OFS, 32'h0, RESP_OK);
      for (int a = 0; a < 4; a++)
      begin
         wr(CTRL_OFS, ctl(0, 0, 0, 0, 3'h0, a[1:0]), RESP_OK);
         fb_in <= 12'($urandom);
         repeat (2) @(posedge aclk);
         chk("fb_out", {22'h0, fb_in >> a}, {22'h0, fb_out});
      end
      // even mantissa keeps the half-headroom result exact
      for (int i = 0; i < 6; i++)
      begin
         c = 7'($urandom) & 7'h7E;
         t = (int'(c[3:0]) << c[6:4]) * 25;
         adv(c, i[0], 16'(i[0] ? t / 2 : t));
      end
      adv(7'h7F, 0, 16'd48000);
      bemf_amp <= 9'h120;
      adv(7'h7F, 1, 16'h0);
      wr(CTRL_OFS, ctl(0, 0, 1, 0, 3'h0, 2'h0), RESP_OK);
      wr(SPD_OFS, 32'h1FF, RESP_OK);
      hi_cyc <= 16'($urandom_range(1, 30));
      lo_cyc <= 16'($urandom_range(1, 30));
      wait_stop(0, 5);
      wait_dmd(9'h1FF, 9000, n);
      chk("full_ramp_ok", 34'h1, {33'h0, n >= 511 * 16 - 24});
      rd(DMD_OFS, {RESP_OK, 23'h0, 9'h1FF});
      for (int s = 0; s < 8; s++)
      begin
         wr(CTRL_OFS, ctl(0, 0, 1, 0, s[2:0], 2'h0), RESP_OK);
         wr(SPD_OFS, s[0] ? 32'h1FF : 32'h1FD, RESP_OK);
         wait_dmd(s[0] ? 9'h1FF : 9'h1FD, 5000, n);
         chk("slew_span_ok", 34'h1, {33'h0, n >= (16 << s) - 4 && n <= (32 << s) + 8});
      end
      for (int r = 0; r < 2; r++)
      begin
         wr(CTRL_OFS, ctl(0, r[0], 1, 0, 3'h0, 2'h0), RESP_OK);
         pwm_per(r[0] ? int'(PER_HI) : int'(PER_LO));
      end
      wr(SPD_OFS, 32'h0, RESP_OK);
      hi_cyc <= 16'h0000;
      wait_stop(1, 5);
      wr(CTRL_OFS, ctl(0, 0, 0, 0, 3'h0, 2'h0), RESP_OK);
      wait_stop(1, 10);
      for (int k = 0; k < 4; k++)
      begin
         @(posedge aclk);
         adc_level <= LV[k];
         wait_stop(k == 0, 10);
      end
      wait_dmd(9'h1FF, 9000, n);
      adc_level <= 10'h000;
      wait_stop(1, 10);
      wr(CTRL_OFS, ctl(1, 0, 0, 0, 3'h0, 2'h0), RESP_OK);
      hi_cyc <= 16'd10;
      lo_cyc <= 16'd30;
      wait_stop(0, 1200);
      hi_cyc <= 16'd40;
      lo_cyc <= 16'd0;
      wait_dmd(9'h1FF, 9000, n);
      hi_cyc <= 16'h0000;
      wait_stop(1, int'(STOP_N) + 1200);
      tally_and_finish();
   end
endmodule : bsc_top_tb_top
